//--- design/wpd_consts.svh
// constants for the white-led pwm dimming control
// assumes a 250 MHz core clock and an 8-bit register address space
`ifndef WPD_CONSTS_SVH
`define WPD_CONSTS_SVH

`define WPD_ADDR_ENFREQ   8'h18
`define WPD_ADDR_DIM      8'h19
`define WPD_ENFREQ_RST    8'h10
`define WPD_DIM_RST       8'h1D
`define WPD_EN_BIT        7
`define WPD_FREQ_MSB      5
`define WPD_FREQ_LSB      4
`define WPD_RANGE_BIT     7
`define WPD_DUTY_MSB      6
`define WPD_ENFREQ_MASK   8'hB0
`define WPD_DUTY_MAX      7'h63
`define WPD_LAST_STEP     7'h63
`define WPD_CLK_HZ        250000000
`define WPD_FREQ0_HZ      100
`define WPD_FREQ1_HZ      200
`define WPD_FREQ2_HZ      500
`define WPD_FREQ3_HZ      1000
`define WPD_STEPS         100
`define WPD_STEP_CYC(f)   ((`WPD_CLK_HZ) / ((f) * (`WPD_STEPS)))

`endif

//--- design/wpd_pkg.sv
// types for the white-led pwm dimming control
// assumes wpd_consts.svh for all numeric constants
package wpd_pkg;

    typedef struct packed {
        logic       en;          // sink_enable_bit
        logic [1:0] freq;        // dimming frequency code
        logic       range_high;  // 1 = high_range_reference
        logic [6:0] duty;        // pwm_duty_field
    } wpd_cfg_t;

    typedef struct packed {
        logic       wr;          // write strobe
        logic       rd;          // read strobe
        logic [7:0] addr;        // register address
        logic [7:0] wdata;       // write data
    } wpd_req_t;

endpackage

//--- design/wpd_top.sv
// pwm dimming control for a two-sink white-led boost driver
// assumes a register port driven from logic on the same clock (serial interface front end)
//
// How it works
// - one pwm signal gates both sinks together; default frequency after reset 200 Hz.
// - duty programmable 1% to 100% in 1% steps; reset default 30%.
// - range bit set selects the high range reference for both sinks.
// - range bit clear, the reset default, selects the low range reference.
// - enable, duty and frequency are software settings in the two control registers.
// - frequency code 00/01/10/11 gives 100/200/500/1000 Hz.
// - duty code n gives n+1 percent; codes above 63h give 0%.
// - enable bit 1 runs sinks and boost; 0 turns both off.
`include "wpd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wpd_top #(
    parameter logic [15:0] STEP_CYC_F0 = 16'(`WPD_STEP_CYC(`WPD_FREQ0_HZ)), // per 1% at 100 Hz
    parameter logic [15:0] STEP_CYC_F1 = 16'(`WPD_STEP_CYC(`WPD_FREQ1_HZ)), // per 1% at 200 Hz
    parameter logic [15:0] STEP_CYC_F2 = 16'(`WPD_STEP_CYC(`WPD_FREQ2_HZ)), // per 1% at 500 Hz
    parameter logic [15:0] STEP_CYC_F3 = 16'(`WPD_STEP_CYC(`WPD_FREQ3_HZ))  // per 1% at 1 kHz
) (
    input  wire logic             clk,            // 250 MHz core clock
    input  wire logic             rst,            // async reset, active high
    input  wire wpd_pkg::wpd_req_t reg_req,       // register access request
    output logic [7:0]            reg_rdata,      // read data, valid cycle after rd
    output logic                  led_sink_a_on,  // gate for sink a
    output logic                  led_sink_b_on,  // gate for sink b
    output logic                  boost_en,       // boost converter enable
    output logic                  range_high_sel  // 1 high range ref, 0 low range ref
);
    import wpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] led_enable_freq_reg_ff;
    logic [7:0] led_dimming_control_ff;
    wpd_cfg_t   reg_cfg;
    wpd_cfg_t   act_cfg_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_enable_freq_reg_ff <= `WPD_ENFREQ_RST;
            led_dimming_control_ff <= `WPD_DIM_RST;
        end else if (reg_req.wr) begin
            if (reg_req.addr == `WPD_ADDR_ENFREQ) begin
                led_enable_freq_reg_ff <= reg_req.wdata & `WPD_ENFREQ_MASK;
            end else if (reg_req.addr == `WPD_ADDR_DIM) begin
                led_dimming_control_ff <= reg_req.wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            if (reg_req.addr == `WPD_ADDR_ENFREQ) begin
                reg_rdata <= led_enable_freq_reg_ff;
            end else if (reg_req.addr == `WPD_ADDR_DIM) begin
                reg_rdata <= led_dimming_control_ff;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    always_comb begin
        reg_cfg.en         = led_enable_freq_reg_ff[`WPD_EN_BIT];
        reg_cfg.freq       = led_enable_freq_reg_ff[`WPD_FREQ_MSB:`WPD_FREQ_LSB];
        reg_cfg.range_high = led_dimming_control_ff[`WPD_RANGE_BIT];
        reg_cfg.duty       = led_dimming_control_ff[`WPD_DUTY_MSB:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // period timing

    logic [15:0] prescale_ff;
    logic [6:0]  step_ff;
    logic [15:0] step_len;
    logic        tick;
    logic        period_end;
    logic [6:0]  duty_pct;

    always_comb begin
        case (act_cfg_ff.freq)
            2'b00:   step_len = STEP_CYC_F0;
            2'b01:   step_len = STEP_CYC_F1;
            2'b10:   step_len = STEP_CYC_F2;
            default: step_len = STEP_CYC_F3;
        endcase
    end

    assign tick       = (prescale_ff == step_len - 16'h0001);
    assign period_end = tick && (step_ff == `WPD_LAST_STEP);

    // counters rest at zero until the new settings are latched, so enabling
    // starts a whole period at the frequency just written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale_ff <= 16'h0000;
            step_ff     <= 7'h00;
        end else if (!reg_cfg.en || !act_cfg_ff.en) begin
            prescale_ff <= 16'h0000;
            step_ff     <= 7'h00;
        end else if (tick) begin
            prescale_ff <= 16'h0000;
            step_ff     <= period_end ? 7'h00 : step_ff + 7'h01;
        end else begin
            prescale_ff <= prescale_ff + 16'h0001;
        end
    end

    // settings track the registers while idle and on the first enabled cycle;
    // once running they move only at period end, so no pulse is cut short
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_cfg_ff <= '0;
        end else if (!reg_cfg.en || !act_cfg_ff.en || period_end) begin
            act_cfg_ff <= reg_cfg;
        end
    end

    assign duty_pct = (act_cfg_ff.duty > `WPD_DUTY_MAX) ? 7'h00
                                                         : act_cfg_ff.duty + 7'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    logic pwm_on;
    // held low for the one cycle before the settings latch: a pulse drawn from
    // stale settings would be cut off at the first boundary
    assign pwm_on = reg_cfg.en && act_cfg_ff.en && (step_ff < duty_pct);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_sink_a_on <= 1'b0;
            led_sink_b_on <= 1'b0;
        end else begin
            led_sink_a_on <= pwm_on;
            led_sink_b_on <= pwm_on;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boost_en <= 1'b0;
        end else begin
            boost_en <= reg_cfg.en;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            range_high_sel <= 1'b0;
        end else begin
            range_high_sel <= act_cfg_ff.range_high;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_idle_two;
        !reg_cfg.en ##1 !reg_cfg.en;
    endsequence

    sequence s_full_duty;
        reg_cfg.en && act_cfg_ff.en && (duty_pct == 7'h64);
    endsequence

    sequence s_fresh_period;
        (step_ff == 7'h00) && (prescale_ff == 16'h0000);
    endsequence

    chk_sinks_together: assert property (@(posedge clk) disable iff (rst)
        led_sink_a_on == led_sink_b_on)
        else $error("sinks not gated together");

    chk_off_when_idle: assert property (@(posedge clk) disable iff (rst)
        !reg_cfg.en |=> !led_sink_a_on && !led_sink_b_on && !boost_en)
        else $error("sinks or boost on while disabled");

    chk_boost_on: assert property (@(posedge clk) disable iff (rst)
        reg_cfg.en |=> boost_en)
        else $error("boost not enabled");

    chk_over_range: assert property (@(posedge clk) disable iff (rst)
        (act_cfg_ff.duty > `WPD_DUTY_MAX) |=> !led_sink_a_on)
        else $error("over-range duty code drove sinks");

    chk_full_duty: assert property (@(posedge clk) disable iff (rst)
        s_full_duty |=> led_sink_a_on)
        else $error("full duty dropped the sinks");

    chk_range_follow: assert property (@(posedge clk) disable iff (rst)
        s_idle_two |=> range_high_sel == $past(reg_cfg.range_high, 2))
        else $error("range select not applied");

    chk_boundary_only: assert property (@(posedge clk) disable iff (rst)
        $past(reg_cfg.en) && $past(act_cfg_ff.en) && !$past(period_end) |-> $stable(act_cfg_ff))
        else $error("settings changed inside a period");

    chk_enable_start: assert property (@(posedge clk) disable iff (rst)
        $rose(act_cfg_ff.en) |-> s_fresh_period)
        else $error("enabling did not start a whole period");

    chk_period_wrap: assert property (@(posedge clk) disable iff (rst)
        period_end |=> s_fresh_period)
        else $error("period did not restart at its end");

    chk_step_bound: assert property (@(posedge clk) disable iff (rst)
        step_ff <= `WPD_LAST_STEP && prescale_ff < step_len)
        else $error("period counter out of range");

    chk_duty_edge: assert property (@(posedge clk) disable iff (rst)
        reg_cfg.en && (step_ff == duty_pct) |=> !led_sink_a_on)
        else $error("pulse longer than duty");

endmodule

`default_nettype wire

//--- tb/wpd_led_model.sv
// model of the two led strings hanging on the sinks
// assumes both sink gates are registered on clk; clr held at time zero
`timescale 1ns/1ps
`default_nettype none

module wpd_led_model (
    input  wire logic        clk,     // core clock
    input  wire logic        sink_a,  // gate of string a
    input  wire logic        sink_b,  // gate of string b
    input  wire logic        clr,     // restart the counts
    output logic [15:0]      lit_cnt, // cycles lit since clr
    output logic             split    // strings seen apart
);
    // a string only counts its own current; the pair must agree every cycle
    always_ff @(posedge clk) begin
        lit_cnt <= clr ? 16'h0000 : lit_cnt + 16'(sink_a);
        split   <= clr ? 1'b0 : (split | (sink_a !== sink_b));
    end
endmodule

`default_nettype wire

//--- tb/wpd_top_tb.sv
// self-checking bench for the pwm dimming control
// assumes step lengths shortened to 4,3,2,1 clocks per percent
`include "wpd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wpd_top_tb;
    import wpd_pkg::*;
    logic            clk, rst, sa, sb, boost, rng, clr, split, rngb;
    wpd_req_t        req;
    logic [7:0]      rdata, rd;
    logic [15:0]     lit;
    int              num_errors, checked, seed, duty, i, f;
    int              step [4];

    wpd_top #(.STEP_CYC_F0(16'h0004), .STEP_CYC_F1(16'h0003),
              .STEP_CYC_F2(16'h0002), .STEP_CYC_F3(16'h0001)) u_wpd_top (
        .clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
        .led_sink_a_on(sa), .led_sink_b_on(sb), .boost_en(boost), .range_high_sel(rng));
    wpd_led_model u_wpd_led_model (
        .clk(clk), .sink_a(sa), .sink_b(sb), .clr(clr), .lit_cnt(lit), .split(split));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [15:0] exp_lit(input int d, input int st);
        return (d > 99) ? 16'h0000 : 16'((d + 1) * st);
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // an idle edge after each strobe keeps back-to-back calls from re-driving it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1; req.addr = a; req.wdata = d;
        @(posedge clk) #1;
        req.wr = 1'b0;
        @(posedge clk) #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        req.rd = 1'b1; req.addr = a;
        @(posedge clk) #1;
        req.rd = 1'b0; d = rdata;
        @(posedge clk) #1;
    endtask

    initial begin
        #200000;
        num_errors++;
        summarize();
    end

    initial begin
        seed = 32'hbeab; step = '{4, 3, 2, 1};
        rst = 1'b1; req = '0; clr = 1'b1; num_errors = 0; checked = 0;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        check("sink_rst", {14'h0, sa, boost}, 16'h0000);
        rd_reg(`WPD_ADDR_ENFREQ, rd);
        check("enfreq_rst", {8'h00, rd}, 16'h0010);
        rd_reg(8'h19, rd);
        check("dim_rst", {8'h00, rd}, 16'h001D);
        rd_reg(8'h20, rd);
        check("unmapped", {8'h00, rd}, 16'h0000);
        wr_reg(`WPD_ADDR_ENFREQ, 8'hFF);
        rd_reg(`WPD_ADDR_ENFREQ, rd);
        check("enfreq_mask", {8'h00, rd}, 16'h00B0);
        wr_reg(`WPD_ADDR_ENFREQ, 8'h00);
        for (i = 0; i < 12; i++) begin
            f = i % 4;
            duty = (i == 0) ? 0 : (i == 1) ? 99 : (i == 2) ? 8'h70 : (i == 3) ? 8'h7F
                 : $unsigned($random(seed)) % 100;
            rngb = (i == 1) ? 1'b0 : 1'($random(seed));
            wr_reg(8'h19, {rngb, 7'(duty)});
            rd_reg(8'h19, rd);
            check("dim_rd", {8'h00, rd}, {8'h0, rngb, 7'(duty)});
            wr_reg(`WPD_ADDR_ENFREQ, {2'b10, 2'(f), 4'h0});
            repeat (4) @(posedge clk);
            #1 clr = 1'b1;
            @(posedge clk) #1 clr = 1'b0;
            repeat (100 * step[f]) @(posedge clk);
            #1 check("lit", lit, exp_lit(duty, step[f]));
            check("split", {15'h0, split}, 16'h0000);
            check("range", {15'h0, rng}, {15'h0, rngb});
            check("boost_on", {15'h0, boost}, 16'h0001);
            wr_reg(`WPD_ADDR_ENFREQ, 8'h00);
            @(posedge clk) #1;
            check("sink_off", {14'h0, sa | sb, boost}, 16'h0000);
        end
        summarize();
    end
endmodule

`default_nettype wire
